// File: logic/odx_pkg.sv
/*
 * Shared constants and types for the opcode decoder and subtract/XOR unit.
 * Assumes a 32-bit datapath and 8-bit primary opcodes.
 */
package odx_pkg;
	localparam int DATA_W   = 32;
	localparam int OP_W     = 8;
	localparam int REG_AW   = 8;
	localparam int REG_NUM  = 256;

	// Opcode pair bases (even = register operand, odd = immediate)
	localparam logic [7:0] OP_SUB_SIGNED      = 8'h20;
	localparam logic [7:0] OP_SUB_UNSIGNED    = 8'h22;
	localparam logic [7:0] OP_SUBC_SIGNED     = 8'h28;
	localparam logic [7:0] OP_SUBC_UNSIGNED   = 8'h2A;
	localparam logic [7:0] OP_RSUBC_SIGNED    = 8'h38;
	localparam logic [7:0] OP_RSUBC_UNSIGNED  = 8'h3A;
	localparam logic [7:0] OP_CMP_LE_U        = 8'h46;
	localparam logic [7:0] OP_ASSERT_LE_S     = 8'h54;
	localparam logic [7:0] OP_ASSERT_LE_U     = 8'h56;
	localparam logic [7:0] OP_ASSERT_GE_S     = 8'h5C;
	localparam logic [7:0] OP_ASSERT_GE_U     = 8'h5E;
	localparam logic [7:0] OP_CMP_EQ          = 8'h60;
	localparam logic [7:0] OP_CMP_NE          = 8'h62;
	localparam logic [7:0] OP_XOR             = 8'h94;
	localparam logic [7:0] OP_XNOR            = 8'h96;
	localparam logic [7:0] OP_BR_FALSE_DEC    = 8'hB4;
	// Single opcodes
	localparam logic [7:0] OP_INT_RETURN      = 8'h88;
	localparam logic [7:0] OP_INT_RETURN_INV  = 8'h8C;
	localparam logic [7:0] OP_READ_XLAT       = 8'hB6;
	localparam logic [7:0] OP_WRITE_XLAT      = 8'hBE;
	localparam logic [7:0] OP_EMULATE         = 8'hD7;

	// Reset values
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [3:0]  RST_FLAGS = 4'h0;

	// Status flag positions inside the 4-bit flag vector
	localparam int FLAG_V = 3;
	localparam int FLAG_N = 2;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;

	typedef enum logic [4:0] {
		ODX_CLS_OTHER,
		ODX_CLS_SUB_SIGNED_TRAP,
		ODX_CLS_SUB_UNSIGNED_TRAP,
		ODX_CLS_SUB_CARRY_SIGNED,
		ODX_CLS_SUB_CARRY_UNSIGNED,
		ODX_CLS_REV_SUB_CARRY_SIGNED,
		ODX_CLS_REV_SUB_CARRY_UNSIGNED,
		ODX_CLS_CMP_LE_UNSIGNED,
		ODX_CLS_ASSERT_LE_SIGNED,
		ODX_CLS_ASSERT_LE_UNSIGNED,
		ODX_CLS_ASSERT_GE_SIGNED,
		ODX_CLS_ASSERT_GE_UNSIGNED,
		ODX_CLS_CMP_EQUAL,
		ODX_CLS_CMP_NOT_EQUAL,
		ODX_CLS_XOR,
		ODX_CLS_XNOR,
		ODX_CLS_BRANCH_FALSE_DEC,
		ODX_CLS_INT_RETURN,
		ODX_CLS_INT_RETURN_INV,
		ODX_CLS_READ_XLAT,
		ODX_CLS_WRITE_XLAT,
		ODX_CLS_EMULATE
	} odx_class_t;
endpackage

// File: logic/odx_regfile.sv
/*
 * General register file for the decode/execute unit: 256 x 32 words,
 * two registered read ports and one write port.
 * Assumes a single synchronous clock; read data appear one edge after
 * the address.
 */
`timescale 1ns/10ps
module odx_regfile
	import odx_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic [REG_AW-1:0] rd_addr_a,
	input  wire logic [REG_AW-1:0] rd_addr_b,
	output logic      [DATA_W-1:0] rd_data_a,
	output logic      [DATA_W-1:0] rd_data_b,
	input  wire logic              wr_en,
	input  wire logic [REG_AW-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data
);
	// Two-state storage: words read before their first write give zero, not unknown
	bit   [DATA_W-1:0] mem [REG_NUM];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_a <= mem[rd_addr_a];
		rd_data_b <= mem[rd_addr_b];
	end
endmodule // odx_regfile

// File: logic/odx_decode_exec.sv
/*
 * Primary opcode decoder with execution of signed/unsigned subtract,
 * exclusive-OR and exclusive-NOR. Other opcodes are only classified.
 * Assumes the pipeline holds issue_valid for one cycle per instruction;
 * instructions may issue back to back. Results land three edges later.
 */
// Notes on behaviour
// - Signed subtract writes A plus two's complement of B to the target.
// - Signed subtract overflow raises the out-of-range trap.
// - Signed subtract writes its result even when it overflows.
// - Unsigned subtract computes A minus B; underflow raises out-of-range trap.
// - Unsigned subtract writes its result even when it underflows.
// - Operand B is register when mode bit is zero, zero-extended immediate otherwise.
// - XOR writes bitwise A exclusive-OR B to the target.
// - XNOR writes the inverted bitwise exclusive-OR of A and B.
// - Pairs 28/29 and 2A/2B decode as signed and unsigned subtract-with-carry.
// - Pairs 38/39 and 3A/3B decode as reverse subtract-with-carry, signed and unsigned.
// - Pair 46/47 decodes as unsigned compare less-than-or-equal.
// - Pairs 54/55 and 56/57 decode as assert less-or-equal, signed and unsigned.
// - Pairs 5C/5D and 5E/5F decode as assert greater-or-equal, signed and unsigned.
// - Pair 60/61 decodes compare-equal; 62/63 compare-not-equal.
// - Opcode B6 decodes as read translation entry; BE decodes as write translation entry.
// - Opcode D7 decodes as a trap to software emulation.
// - Opcode 8C is interrupt return with invalidate, distinct from 88.
// - Pair B4/B5 decodes as branch-false-and-decrement.
`timescale 1ns/10ps
module odx_decode_exec
	import odx_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              srst,
	input  wire logic              issue_valid,
	input  wire logic [OP_W-1:0]   opcode,
	input  wire logic [REG_AW-1:0] result_target,
	input  wire logic [REG_AW-1:0] operand_a_sel,
	input  wire logic [REG_AW-1:0] operand_b_sel,
	input  wire logic [7:0]        imm8,
	output logic                   dec_valid,
	output odx_class_t             dec_class,
	output logic                   dec_imm_mode,
	output logic                   wb_valid,
	output logic      [REG_AW-1:0] wb_target,
	output logic      [DATA_W-1:0] wb_data,
	output logic                   trap_out_of_range,
	output logic      [3:0]        flags,
	output logic      [3:0]        flags_update
);
	// Pipeline: stage 1 decodes and reads registers, stage 2 executes
	typedef struct packed {
		logic              s1_valid;
		odx_class_t        s1_class;
		logic              s1_imm;
		logic [7:0]        s1_imm8;
		logic [REG_AW-1:0] s1_target;
		logic              dec_valid;
		odx_class_t        dec_class;
		logic              dec_imm_mode;
		logic              wb_valid;
		logic [REG_AW-1:0] wb_target;
		logic [DATA_W-1:0] wb_data;
		logic              trap;
		logic [3:0]        flags;
		logic [3:0]        flags_update;
	} odx_state_t;

	odx_state_t        st;
	odx_state_t        next_st;
	logic [DATA_W-1:0] rf_a;
	logic [DATA_W-1:0] rf_b;

	function automatic odx_class_t odx_classify(input logic [OP_W-1:0] op);
		logic [OP_W-1:0] pair;
		odx_class_t      cls;
		pair = {op[OP_W-1:1], 1'b0};
		cls  = ODX_CLS_OTHER;
		if (op == OP_INT_RETURN_INV) begin
			cls = ODX_CLS_INT_RETURN_INV;
		end else if (op == OP_INT_RETURN) begin
			cls = ODX_CLS_INT_RETURN;
		end else if (op == OP_READ_XLAT) begin
			cls = ODX_CLS_READ_XLAT;
		end else if (op == OP_WRITE_XLAT) begin
			cls = ODX_CLS_WRITE_XLAT;
		end else if (op == OP_EMULATE) begin
			cls = ODX_CLS_EMULATE;
		end else if (pair == OP_SUB_SIGNED) begin
			cls = ODX_CLS_SUB_SIGNED_TRAP;
		end else if (pair == OP_SUB_UNSIGNED) begin
			cls = ODX_CLS_SUB_UNSIGNED_TRAP;
		end else if (pair == OP_SUBC_SIGNED) begin
			cls = ODX_CLS_SUB_CARRY_SIGNED;
		end else if (pair == OP_SUBC_UNSIGNED) begin
			cls = ODX_CLS_SUB_CARRY_UNSIGNED;
		end else if (pair == OP_RSUBC_SIGNED) begin
			cls = ODX_CLS_REV_SUB_CARRY_SIGNED;
		end else if (pair == OP_RSUBC_UNSIGNED) begin
			cls = ODX_CLS_REV_SUB_CARRY_UNSIGNED;
		end else if (pair == OP_CMP_LE_U) begin
			cls = ODX_CLS_CMP_LE_UNSIGNED;
		end else if (pair == OP_ASSERT_LE_S) begin
			cls = ODX_CLS_ASSERT_LE_SIGNED;
		end else if (pair == OP_ASSERT_LE_U) begin
			cls = ODX_CLS_ASSERT_LE_UNSIGNED;
		end else if (pair == OP_ASSERT_GE_S) begin
			cls = ODX_CLS_ASSERT_GE_SIGNED;
		end else if (pair == OP_ASSERT_GE_U) begin
			cls = ODX_CLS_ASSERT_GE_UNSIGNED;
		end else if (pair == OP_CMP_EQ) begin
			cls = ODX_CLS_CMP_EQUAL;
		end else if (pair == OP_CMP_NE) begin
			cls = ODX_CLS_CMP_NOT_EQUAL;
		end else if (pair == OP_XOR) begin
			cls = ODX_CLS_XOR;
		end else if (pair == OP_XNOR) begin
			cls = ODX_CLS_XNOR;
		end else if (pair == OP_BR_FALSE_DEC) begin
			cls = ODX_CLS_BRANCH_FALSE_DEC;
		end
		return cls;
	endfunction

	// Only true operand pairs carry the mode bit
	function automatic logic odx_is_pair(input odx_class_t cls);
		return !(cls inside {ODX_CLS_OTHER, ODX_CLS_INT_RETURN, ODX_CLS_INT_RETURN_INV,
			ODX_CLS_READ_XLAT, ODX_CLS_WRITE_XLAT, ODX_CLS_EMULATE});
	endfunction

	odx_regfile u_regfile (
		.sys_clk   (sys_clk),
		.rd_addr_a (operand_a_sel),
		.rd_addr_b (operand_b_sel),
		.rd_data_a (rf_a),
		.rd_data_b (rf_b),
		.wr_en     (st.wb_valid),
		.wr_addr   (st.wb_target),
		.wr_data   (st.wb_data)
	);

	always_comb begin
		odx_class_t        cls;
		logic [DATA_W-1:0] op_a;
		logic [DATA_W-1:0] op_b;
		logic [DATA_W:0]   diff;
		logic [DATA_W-1:0] res;
		cls  = odx_classify(opcode);
		op_a = RST_WORD;
		op_b = RST_WORD;
		diff = {1'b0, RST_WORD};
		res  = RST_WORD;
		next_st = st;

		next_st.s1_valid  = issue_valid;
		next_st.s1_class  = cls;
		// low opcode bit is the mode bit
		next_st.s1_imm    = opcode[0] & odx_is_pair(cls);
		next_st.s1_imm8   = imm8;
		next_st.s1_target = result_target;
		next_st.dec_valid    = issue_valid;
		next_st.dec_class    = cls;
		next_st.dec_imm_mode = opcode[0] & odx_is_pair(cls);

		next_st.wb_valid     = 1'b0;
		next_st.trap         = 1'b0;
		next_st.flags_update = 4'h0;

		op_a = rf_a;
		op_b = st.s1_imm ? {24'h00_0000, st.s1_imm8} : rf_b;
		diff = {1'b0, op_a} + {1'b0, ~op_b} + 33'h0_0000_0001;

		if (st.s1_valid) begin
			case (st.s1_class)
				ODX_CLS_SUB_SIGNED_TRAP,
				ODX_CLS_SUB_UNSIGNED_TRAP: begin
					res = diff[DATA_W-1:0];
					next_st.wb_valid  = 1'b1;
					next_st.wb_target = st.s1_target;
					next_st.wb_data   = res;
					next_st.flags_update = 4'hF;
					next_st.flags[FLAG_V] = (op_a[31] != op_b[31]) && (res[31] != op_a[31]);
					next_st.flags[FLAG_N] = res[31];
					next_st.flags[FLAG_Z] = (res == RST_WORD);
					next_st.flags[FLAG_C] = diff[DATA_W];
					if (st.s1_class == ODX_CLS_SUB_SIGNED_TRAP) begin
						next_st.trap = (op_a[31] != op_b[31]) && (res[31] != op_a[31]);
					end else begin
						// unsigned underflow when no carry out
						next_st.trap = !diff[DATA_W];
					end
				end
				ODX_CLS_XOR,
				ODX_CLS_XNOR: begin
					res = op_a ^ op_b;
					if (st.s1_class == ODX_CLS_XNOR) begin
						res = ~res;
					end
					next_st.wb_valid  = 1'b1;
					next_st.wb_target = st.s1_target;
					next_st.wb_data   = res;
					next_st.flags_update = 4'h6;
					next_st.flags[FLAG_N] = res[31];
					next_st.flags[FLAG_Z] = (res == RST_WORD);
				end
				default: begin
					next_st.wb_valid = 1'b0;
				end
			endcase
		end

		if (srst) begin
			next_st = '0;
			next_st.flags = RST_FLAGS;
		end
	end

	always_ff @(posedge sys_clk) begin
		st <= next_st;
	end

	always_comb begin
		dec_valid         = st.dec_valid;
		dec_class         = st.dec_class;
		dec_imm_mode      = st.dec_imm_mode;
		wb_valid          = st.wb_valid;
		wb_target         = st.wb_target;
		wb_data           = st.wb_data;
		trap_out_of_range = st.trap;
		flags             = st.flags;
		flags_update      = st.flags_update;
	end
endmodule // odx_decode_exec

// File: sim/odx_decode_exec_props.sv
/* Checker for the decoder and subtract/XOR unit, on its ports only.
   Assumes one clock and the synchronous reset srst. */
`timescale 1ns/10ps
module odx_decode_exec_props
	import odx_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              srst,
	input wire logic              issue_valid,
	input wire logic [OP_W-1:0]   opcode,
	input wire logic [REG_AW-1:0] result_target,
	input wire logic [REG_AW-1:0] operand_a_sel,
	input wire logic [REG_AW-1:0] operand_b_sel,
	input wire logic [7:0]        imm8,
	input wire logic              dec_valid,
	input wire odx_class_t        dec_class,
	input wire logic              dec_imm_mode,
	input wire logic              wb_valid,
	input wire logic [REG_AW-1:0] wb_target,
	input wire logic [DATA_W-1:0] wb_data,
	input wire logic              trap_out_of_range,
	input wire logic [3:0]        flags,
	input wire logic [3:0]        flags_update
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_subc_decode: assert property (
		issue_valid && opcode[7:1] == 7'h14 |=> dec_valid && dec_class == ODX_CLS_SUB_CARRY_SIGNED)
		else $error("carry subtract decoded wrongly");
	a_int_return_inv: assert property (
		issue_valid && opcode == 8'h8C |=> dec_class == ODX_CLS_INT_RETURN_INV)
		else $error("return with invalidate decoded wrongly");
	a_emulate_single: assert property (
		issue_valid && opcode == 8'hD7 |=> dec_class == ODX_CLS_EMULATE && !dec_imm_mode)
		else $error("emulation trap decoded wrongly");
	a_xor_mode: assert property (
		issue_valid && opcode[7:1] == 7'h4A |=> dec_imm_mode == $past(opcode[0]))
		else $error("operand mode not taken from opcode bit zero");
	a_sub_write: assert property (
		issue_valid && opcode[7:2] == 6'h08 |-> ##2 wb_valid && flags_update == 4'hF
		&& wb_target == $past(result_target, 2)) else $error("subtract writeback missing");
	a_xor_write: assert property (
		issue_valid && opcode[7:2] == 6'h25 |-> ##2 wb_valid && flags_update == 4'h6)
		else $error("logic writeback missing");
	a_signed_trap: assert property (
		issue_valid && opcode[7:1] == 7'h10 |-> ##2 trap_out_of_range == flags[FLAG_V])
		else $error("signed trap does not follow overflow");
	a_unsigned_trap: assert property (
		issue_valid && opcode[7:1] == 7'h11 |-> ##2 trap_out_of_range == !flags[FLAG_C])
		else $error("unsigned trap does not follow borrow");
	a_nz_flags: assert property (
		flags_update[FLAG_Z] |-> flags[FLAG_Z] == (wb_data == 32'h0000_0000)
		&& flags[FLAG_N] == wb_data[31]) else $error("zero or negative flag wrong");
	a_vc_kept: assert property (
		flags_update == 4'h6 |-> flags[FLAG_V] == $past(flags[FLAG_V])
		&& flags[FLAG_C] == $past(flags[FLAG_C])) else $error("logic op changed V or C");
endmodule // odx_decode_exec_props

bind odx_decode_exec odx_decode_exec_props odx_decode_exec_props_inst (
	.sys_clk(sys_clk), .srst(srst), .issue_valid(issue_valid), .opcode(opcode),
	.result_target(result_target), .operand_a_sel(operand_a_sel),
	.operand_b_sel(operand_b_sel), .imm8(imm8), .dec_valid(dec_valid),
	.dec_class(dec_class), .dec_imm_mode(dec_imm_mode), .wb_valid(wb_valid),
	.wb_target(wb_target), .wb_data(wb_data), .trap_out_of_range(trap_out_of_range),
	.flags(flags), .flags_update(flags_update)
);

// File: sim/odx_far_model.sv
/* Pipeline-side model: shadow register file and status flags, with the
   result each subtract or logic op must give. Assumes the bench updates
   it once per retired instruction. */
`timescale 1ns/10ps
module odx_far_model
	import odx_pkg::*;
;
	logic [DATA_W-1:0] regs [REG_NUM];
	logic [3:0]        flg;

	function automatic logic [36:0] exec(input logic [7:0] op, input logic [31:0] a, b);
		logic [32:0] s;
		logic [31:0] d;
		logic        t;
		logic [3:0]  f;
		s = {1'b0, a} + {1'b0, ~b} + 33'h0_0000_0001;
		t = 1'b0;
		f = flg;
		d = a ^ b;
		if (op[7:2] == 6'h08) begin
			d = s[31:0];
			f = {a[31] != b[31] && s[31] != a[31], s[31], ~|d, s[32]};
			t = op[1] ? !s[32] : f[FLAG_V];
		end else begin
			if (op[1]) d = ~d;
			f[FLAG_N] = d[31];
			f[FLAG_Z] = ~|d;
		end
		return {t, f, d};
	endfunction
endmodule // odx_far_model

// File: sim/odx_decode_exec_test.sv
/* Self-checking bench for odx_decode_exec: decode table, arithmetic and
   trap cases, back-to-back issue and reset in mid-run.
   Assumes odx_far_model predicts register contents. */
`timescale 1ns/10ps
module odx_decode_exec_test
	import odx_pkg::*;
;
	typedef struct packed {
		logic [7:0] op;
		odx_class_t cls;
		logic [3:0] fu;
	} odx_row_t;
	logic              sys_clk = 1'b0;
	logic              srst = 1'b1;
	logic              issue_valid = 1'b0;
	logic [7:0]        opcode = 8'h00;
	logic [7:0]        result_target = 8'h00;
	logic [7:0]        operand_a_sel = 8'h00;
	logic [7:0]        operand_b_sel = 8'h00;
	logic [7:0]        imm8 = 8'h00;
	logic              dec_valid, dec_imm_mode, wb_valid, trap_out_of_range;
	odx_class_t        dec_class;
	logic [7:0]        wb_target;
	logic [31:0]       wb_data, last;
	logic [3:0]        flags, flags_update;
	int                fail_count = 0;
	int                checks = 0;
	bit                data_ok = 1'b0;
	odx_row_t          rows [23];

	always #2 sys_clk = ~sys_clk;

	odx_decode_exec odx_decode_exec_inst (
		.sys_clk(sys_clk), .srst(srst), .issue_valid(issue_valid), .opcode(opcode),
		.result_target(result_target), .operand_a_sel(operand_a_sel),
		.operand_b_sel(operand_b_sel), .imm8(imm8), .dec_valid(dec_valid),
		.dec_class(dec_class), .dec_imm_mode(dec_imm_mode), .wb_valid(wb_valid),
		.wb_target(wb_target), .wb_data(wb_data), .trap_out_of_range(trap_out_of_range),
		.flags(flags), .flags_update(flags_update)
	);
	odx_far_model odx_far_model_inst ();

	task automatic chk(input logic [36:0] got, exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Issue at a falling edge, check decode and writeback, leave the write time to land
	task automatic run(input odx_row_t r, input logic md, input logic [7:0] rc, ra, rb, im);
		logic [31:0] b;
		logic [36:0] e;
		b = md ? {24'h00_0000, im} : odx_far_model_inst.regs[rb];
		e = odx_far_model_inst.exec(r.op | {7'h00, md}, odx_far_model_inst.regs[ra], b);
		opcode = r.op | {7'h00, md};
		result_target = rc;
		operand_a_sel = ra;
		operand_b_sel = rb;
		imm8 = im;
		issue_valid = 1'b1;
		@(negedge sys_clk);
		issue_valid = 1'b0;
		chk({dec_valid, dec_class, dec_imm_mode}, {1'b1, r.cls, md});
		@(negedge sys_clk);
		last = wb_data;
		chk({wb_valid, flags_update}, {|r.fu, r.fu});
		if (|r.fu) chk(wb_target, rc);
		if (|r.fu && data_ok) begin
			chk({trap_out_of_range, flags, wb_data}, e);
			odx_far_model_inst.regs[rc] = e[31:0];
			odx_far_model_inst.flg = e[35:32];
		end
		repeat (2) @(negedge sys_clk);
	endtask

	initial begin
		rows = '{'{8'h20, ODX_CLS_SUB_SIGNED_TRAP, 4'hF}, '{8'h22, ODX_CLS_SUB_UNSIGNED_TRAP, 4'hF},
			'{8'h28, ODX_CLS_SUB_CARRY_SIGNED, 4'h0}, '{8'h2A, ODX_CLS_SUB_CARRY_UNSIGNED, 4'h0},
			'{8'h38, ODX_CLS_REV_SUB_CARRY_SIGNED, 4'h0},
			'{8'h3A, ODX_CLS_REV_SUB_CARRY_UNSIGNED, 4'h0},
			'{8'h46, ODX_CLS_CMP_LE_UNSIGNED, 4'h0}, '{8'h54, ODX_CLS_ASSERT_LE_SIGNED, 4'h0},
			'{8'h56, ODX_CLS_ASSERT_LE_UNSIGNED, 4'h0}, '{8'h5C, ODX_CLS_ASSERT_GE_SIGNED, 4'h0},
			'{8'h5E, ODX_CLS_ASSERT_GE_UNSIGNED, 4'h0}, '{8'h60, ODX_CLS_CMP_EQUAL, 4'h0},
			'{8'h62, ODX_CLS_CMP_NOT_EQUAL, 4'h0}, '{8'h94, ODX_CLS_XOR, 4'h6},
			'{8'h96, ODX_CLS_XNOR, 4'h6}, '{8'hB4, ODX_CLS_BRANCH_FALSE_DEC, 4'h0},
			'{8'h88, ODX_CLS_INT_RETURN, 4'h0}, '{8'h8C, ODX_CLS_INT_RETURN_INV, 4'h0},
			'{8'hB6, ODX_CLS_READ_XLAT, 4'h0}, '{8'hBE, ODX_CLS_WRITE_XLAT, 4'h0},
			'{8'hD7, ODX_CLS_EMULATE, 4'h0}, '{8'h24, ODX_CLS_OTHER, 4'h0},
			'{8'h00, ODX_CLS_OTHER, 4'h0}};
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		@(negedge sys_clk);
		run(rows[13], 1'b1, 8'h08, 8'h00, 8'h00, 8'h00);
		if (^last !== 1'bx) begin
			data_ok = 1'b1;
			odx_far_model_inst.regs[0] = last;
			odx_far_model_inst.flg = 4'h0;
			run(rows[13], 1'b1, 8'h08, 8'h00, 8'h00, 8'h00);
		end else $display("register file unknown after reset, data cases skipped");
		for (int i = 0; i < 23; i++)
			for (int m = 0; m < 2; m++)
				if (m == 0 || i < 16) run(rows[i], m[0], 8'h10, 8'h00, 8'h00, 8'h00);
		if (data_ok) begin
			run(rows[13], 1'b0, 8'h01, 8'h00, 8'h00, 8'h00);
			run(rows[14], 1'b1, 8'h02, 8'h01, 8'h00, 8'h0F);
			run(rows[1], 1'b1, 8'h03, 8'h01, 8'h00, 8'h01);
			run(rows[1], 1'b1, 8'h07, 8'h02, 8'h00, 8'hF0);
			run(rows[1], 1'b0, 8'h07, 8'h02, 8'h02, 8'h00);
			run(rows[13], 1'b1, 8'h04, 8'h01, 8'h00, 8'h01);
			for (int k = 0; k < 31; k++) begin
				run(rows[0], 1'b0, 8'h05, 8'h01, 8'h04, 8'h00);
				run(rows[0], 1'b0, 8'h04, 8'h04, 8'h05, 8'h00);
			end
			run(rows[13], 1'b1, 8'h06, 8'h04, 8'h00, 8'h00);
			chk(last, 32'h8000_0000);
		end
		opcode = 8'h94;
		issue_valid = 1'b1;
		@(negedge sys_clk);
		opcode = 8'h97;
		@(negedge sys_clk);
		issue_valid = 1'b0;
		repeat (2) begin
			chk({wb_valid, flags_update}, 5'h16);
			@(negedge sys_clk);
		end
		chk(wb_valid, 1'b0);
		opcode = 8'h20;
		issue_valid = 1'b1;
		@(negedge sys_clk);
		issue_valid = 1'b0;
		srst = 1'b1;
		@(negedge sys_clk);
		srst = 1'b0;
		chk({dec_valid, wb_valid, trap_out_of_range, flags, flags_update}, 11'h000);
		@(negedge sys_clk);
		odx_far_model_inst.flg = 4'h0;
		run(rows[14], 1'b1, 8'h09, 8'h04, 8'h00, 8'h0F);
		close_out();
	end
endmodule // odx_decode_exec_test
